// [verilog/fcl_loader.v]
// configuration loader: active flash, passive, jtag and mask sources
// Behaviour
// - rising config reset starts active loading
// - user mode only after full programming
// - received bits written into config memory
// - active mode device sequences, drives flash
// - active clock from internal oscillator divider
// - first flash command is wake-up
// - wait at least 30 us before read
// - fast read from address zero, sequential
// - jtag port loads configuration too
// - mask memory option replaces external flash
`timescale 1ns/1ns
`include "fcl_consts.vh"
module fcl_loader #(
  parameter IMAGE_BITS = 4096,  // bits in one image
  parameter DIV        = 4,     // oscillator to flash clock half period
  parameter WAKE_CYC   = (`FCL_WAKE_WAIT_NS * `FCL_CLK_MHZ + 999) / 1000
) (
  // clock and reset
  input  wire       clk,
  input  wire       rst_b,
  // mode straps and control pins
  input  wire [1:0] mode_sel,
  input  wire       config_reset_n,
  // flash link
  output reg        flash_sck,
  output reg        flash_cs_n,
  output reg        flash_mosi,
  input  wire       flash_miso,
  // passive target link
  input  wire       pas_clk,
  input  wire       pas_cs_n,
  input  wire       pas_data,
  // jtag load link
  input  wire       tck,
  input  wire       jtag_load_en,
  input  wire       tdi,
  // mask memory read port
  output reg  [31:0] mask_addr,
  input  wire        mask_data,
  // config memory write port
  output reg        cfg_we,
  output reg [31:0] cfg_addr,
  output reg        cfg_bit,
  // status
  output reg        config_done,
  output reg        user_mode
);
  localparam S_IDLE = 3'h0;  // waiting for reset release
  localparam S_WAKE = 3'h1;  // shifting wake command
  localparam S_WAIT = 3'h2;  // wake recovery
  localparam S_CMD  = 3'h3;  // shifting read command and address
  localparam S_DATA = 3'h4;  // streaming image bits
  localparam S_EXT  = 3'h5;  // passive, jtag or mask loading
  localparam S_DONE = 3'h6;  // user mode

  // first bit of each command is preset at select, so it settles before the first rise
  localparam [39:0] WAKE_WORD = {`FCL_CMD_WAKE, 32'h00000000};
  localparam [39:0] READ_WORD = {`FCL_CMD_FAST_READ, `FCL_START_ADDR, 8'h00};

  wire pcs_n_s;     // passive select, synced
  wire jen_s;       // jtag load enable, synced
  wire [2:0] syn;   // synced pins: crst, pclk, tck
  wire [2:0] rise;  // their rising edges
  wire [2:0] syd;   // synced data pins: pas_data, tdi, miso
  fcl_sync #(.W(3)) u_sync_ctl (
    .clk  (clk),
    .rst_b(rst_b),
    .din  ({config_reset_n, pas_clk, tck}),
    .dout (syn),
    .rise (rise)
  );
  fcl_sync #(.W(5)) u_sync_dat (
    .clk  (clk),
    .rst_b(rst_b),
    .din  ({pas_data, tdi, flash_miso, pas_cs_n, jtag_load_en}),
    .dout ({syd, pcs_n_s, jen_s}),
    .rise ()
  );

  reg [2:0]  st_q;     // state
  reg [1:0]  mode_q;   // strap caught at load start
  reg [15:0] div_q;    // oscillator divider
  reg [15:0] wait_q;   // wake wait counter
  reg [39:0] sh_q;     // outgoing command shifter
  reg [7:0]  nbit_q;   // bits left in command
  reg [31:0] cnt_q;    // image bits written

  wire tick = (div_q == DIV[15:0] - 16'h0001);  // flash clock toggle enable
  wire last = (cnt_q == IMAGE_BITS - 1);

  // oscillator divider, free running
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) div_q <= 16'h0000;
    else if (tick) div_q <= 16'h0000;
    else div_q <= div_q + 16'h0001;
  end

  // main sequencer
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= S_IDLE;
      mode_q <= `FCL_MODE_ACTIVE;
      flash_sck <= 1'b0;
      flash_cs_n <= 1'b1;
      flash_mosi <= 1'b0;
      wait_q <= 16'h0000;
      sh_q <= 40'h0000000000;
      nbit_q <= 8'h00;
      cnt_q <= 32'h00000000;
      mask_addr <= 32'h00000000;
      cfg_we <= 1'b0;
      cfg_addr <= 32'h00000000;
      cfg_bit <= 1'b0;
      config_done <= 1'b0;
      user_mode <= 1'b0;
    end else begin
      cfg_we <= 1'b0;
      if (!syn[2]) begin  // config reset held low: abort and idle
        st_q <= S_IDLE;
        flash_cs_n <= 1'b1;
        flash_sck <= 1'b0;
        config_done <= 1'b0;
        user_mode <= 1'b0;
      end else case (st_q)
        S_IDLE: if (rise[2]) begin
          mode_q <= mode_sel;
          cnt_q <= 32'h00000000;
          mask_addr <= 32'h00000000;
          if (mode_sel == `FCL_MODE_ACTIVE) begin
            st_q <= S_WAKE;
            sh_q <= WAKE_WORD;
            flash_mosi <= WAKE_WORD[39];
            nbit_q <= 8'h08;
            flash_cs_n <= 1'b0;
          end else begin
            st_q <= S_EXT;
          end
        end
        S_WAKE, S_CMD: if (tick) begin  // mode 0: shift on falling sck
          flash_sck <= ~flash_sck;
          if (flash_sck) begin  // falling edge: next bit out, never at a rise
            flash_mosi <= sh_q[38];
            sh_q <= {sh_q[38:0], 1'b0};
            nbit_q <= nbit_q - 8'h01;
            if (nbit_q == 8'h01) begin
              if (st_q == S_WAKE) begin
                st_q <= S_WAIT;
                flash_cs_n <= 1'b1;
                wait_q <= 16'h0000;
              end else begin
                st_q <= S_DATA;
                nbit_q <= `FCL_DUMMY_BITS;  // dummy clocks before data
              end
            end
          end
        end
        S_WAIT: begin
          wait_q <= wait_q + 16'h0001;
          if (wait_q == WAKE_CYC[15:0]) begin
            st_q <= S_CMD;
            flash_cs_n <= 1'b0;
            sh_q <= READ_WORD;
            flash_mosi <= READ_WORD[39];
            nbit_q <= 8'h20;
          end
        end
        S_DATA: if (tick) begin
          flash_sck <= ~flash_sck;
          if (!flash_sck) begin  // sample on rising sck
            if (nbit_q != 8'h00) nbit_q <= nbit_q - 8'h01;
            else begin
              cfg_we <= 1'b1;
              cfg_bit <= syd[0];
              cfg_addr <= cnt_q;
              cnt_q <= cnt_q + 32'h00000001;  // sequential
              if (last) begin
                st_q <= S_DONE;
                flash_cs_n <= 1'b1;
                flash_sck <= 1'b0;  // park clock low with the deselect
              end
            end
          end
        end
        S_EXT: begin
          // mask memory: one bit per cycle, no external flash
          if (mode_q == `FCL_MODE_MASK) begin
            // data belongs to the address shown this cycle, so write it there
            cfg_we <= 1'b1;
            cfg_bit <= mask_data;
            cfg_addr <= mask_addr;
            if (mask_addr == IMAGE_BITS - 1) st_q <= S_DONE;
            else mask_addr <= mask_addr + 32'h00000001;
          end else if ((mode_q == `FCL_MODE_PASSIVE && rise[1] && !pcs_n_s) ||
                       (mode_q == `FCL_MODE_JTAG && rise[0] && jen_s)) begin
            cfg_we <= 1'b1;
            cfg_bit <= (mode_q == `FCL_MODE_JTAG) ? syd[1] : syd[2];
            cfg_addr <= cnt_q;
            cnt_q <= cnt_q + 32'h00000001;
            if (last) st_q <= S_DONE;
          end
        end
        S_DONE: begin
          config_done <= 1'b1;
          user_mode <= 1'b1;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule // fcl_loader

// [include/fcl_consts.vh]
// constants for the configuration loader
`ifndef FCL_CONSTS_VH
`define FCL_CONSTS_VH
`define FCL_CMD_WAKE      8'hab
`define FCL_CMD_FAST_READ 8'h0b
`define FCL_START_ADDR    24'h000000
`define FCL_DUMMY_BITS    8'h08
`define FCL_WAKE_WAIT_NS  30000
`define FCL_CLK_MHZ       50
`define FCL_MODE_ACTIVE   2'h0
`define FCL_MODE_PASSIVE  2'h1
`define FCL_MODE_JTAG     2'h2
`define FCL_MODE_MASK     2'h3
`endif

// [verilog/fcl_sync.v]
// two flip-flop synchroniser for pin inputs, with edge outputs
`timescale 1ns/1ns
module fcl_sync #(
  parameter W = 1  // number of bits
) (
  // clock and reset
  input  wire         clk,
  input  wire         rst_b,
  // async in, sync out
  input  wire [W-1:0] din,
  output wire [W-1:0] dout,
  output wire [W-1:0] rise
);
  reg [W-1:0] s1_q;  // first stage, read only by s2
  reg [W-1:0] s2_q;  // second stage
  reg [W-1:0] s3_q;  // delayed copy for edges

  // sample chain
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign dout = s2_q;
  assign rise = s2_q & ~s3_q;  // edge from stable stages only
endmodule // fcl_sync

// [sim/fcl_chk.sv]
// port checker for the configuration loader
`timescale 1ns/1ns
`include "fcl_consts.vh"
module fcl_chk #(
  parameter IMAGE_BITS = 16,
  parameter WAKE_CYC   = 40
) (
  // clock and reset
  input wire        clk,
  input wire        rst_b,
  // control
  input wire [1:0]  mode_sel,
  input wire        config_reset_n,
  // flash and config memory
  input wire        flash_sck,
  input wire        flash_cs_n,
  input wire        flash_mosi,
  input wire        cfg_we,
  input wire [31:0] cfg_addr,
  input wire        config_done,
  input wire        user_mode
);
  reg [31:0] exp_q; // next expected write address
  reg [15:0] hi_q;  // cycles with flash deselected, saturating
  // saturate from reset so the first select is not judged
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      exp_q <= 32'h0;
      hi_q  <= 16'hffff;
    end else begin
      exp_q <= config_done ? 32'h0 : exp_q + {31'h0, cfg_we};
      hi_q  <= !flash_cs_n ? 16'h0 : hi_q + {15'h0, ~&hi_q};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_high4;
    flash_sck[*4] ##1 !flash_sck;
  endsequence
  a_sck_high: assert property ($rose(flash_sck) |-> s_high4)
    else $error("flash clock high time wrong");
  a_mosi_hold: assert property ($rose(flash_sck) |-> $stable(flash_mosi))
    else $error("mosi moved at clock rise");
  a_idle_clk: assert property (flash_cs_n && $past(flash_cs_n) |-> !flash_sck)
    else $error("flash clock while deselected");
  a_wake_gap: assert property ($fell(flash_cs_n) |-> hi_q >= WAKE_CYC)
    else $error("read too soon after wake");
  a_start_cs: assert property ($rose(config_reset_n) && mode_sel == `FCL_MODE_ACTIVE
    |-> ##[2:12] !flash_cs_n) else $error("active load did not start");
  a_no_user_wr: assert property (user_mode |-> !cfg_we)
    else $error("write in user mode");
  a_done_count: assert property ($rose(config_done) |-> exp_q == IMAGE_BITS)
    else $error("done before whole image");
  a_addr_seq: assert property (cfg_we |-> cfg_addr == exp_q)
    else $error("write address not sequential");
  a_done_hold: assert property (config_done && config_reset_n |=> config_done)
    else $error("done dropped");
endmodule // fcl_chk

// [sim/fcl_flash.sv]
// serial flash model behind the loader
`timescale 1ns/1ns
module fcl_flash #(
  parameter [15:0] IMAGE = 16'hc3a5  // stored image
) (
  // spi pins
  input  wire        sck,
  input  wire        cs_n,
  input  wire        mosi,
  output reg         miso,
  // captured request words
  output reg  [7:0]  wake_cmd,
  output reg  [31:0] rd_hdr
);
  integer   cnt = 0;   // bits in current frame
  integer   frame = 0; // finished frames
  reg [31:0] sh = 32'h0;
  initial begin
    miso = 1'b0;
    wake_cmd = 8'h0;
    rd_hdr = 32'h0;
  end
  // shift in on rising clock
  always @(posedge sck) if (!cs_n) begin
    sh = {sh[30:0], mosi};
    cnt = cnt + 1;
    if (frame == 0 && cnt == 8) wake_cmd = sh[7:0];
    if (frame == 1 && cnt == 32) rd_hdr = sh;
  end
  // data only after a read header, else a moving line
  always @(negedge sck) begin
    if (!cs_n && frame == 1 && cnt >= 40 && cnt < 56) miso = IMAGE[55 - cnt];
    else miso = ~miso;
  end
  // released line shows no stale value
  always @(posedge cs_n) begin
    miso = ~miso;
    if (cnt != 0) frame = frame + 1;
    cnt = 0;
  end
endmodule // fcl_flash

// [sim/testbench.sv]
// testbench for the configuration loader
`timescale 1ns/1ns
`include "fcl_consts.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
  $display("unexpected at %0t: value mismatch", $time); end end
module testbench;
  reg clk = 1'b0, rst_b = 1'b0, config_reset_n = 1'b0, lclk = 1'b0, ldat = 1'b0, len = 1'b0;
  reg [1:0] mode_sel = 2'h0;
  reg [15:0] got = 16'h0; // written bits, first in top position
  wire sck, cs_n, mosi, miso, we, bit_w, done, user;
  wire [31:0] maddr, waddr, hdr;
  wire [7:0] wake;
  integer error_cnt = 0, n_tests = 0, cs_falls = 0;
  localparam [15:0] MASK_IMG = 16'h96e1;
  initial forever #10 clk = ~clk;
  fcl_loader #(.IMAGE_BITS(16), .WAKE_CYC(40)) dut (.clk(clk), .rst_b(rst_b),
    .mode_sel(mode_sel), .config_reset_n(config_reset_n), .flash_sck(sck),
    .flash_cs_n(cs_n), .flash_mosi(mosi), .flash_miso(miso), .pas_clk(lclk),
    .pas_cs_n(~len), .pas_data(ldat), .tck(lclk), .jtag_load_en(len), .tdi(ldat),
    .mask_addr(maddr), .mask_data(MASK_IMG[4'hf - maddr[3:0]]), .cfg_we(we),
    .cfg_addr(waddr), .cfg_bit(bit_w), .config_done(done), .user_mode(user));
  fcl_flash #(.IMAGE(16'hc3a5)) flash (.sck(sck), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .wake_cmd(wake), .rd_hdr(hdr));
  always @(posedge clk) if (we) got[4'hf - waddr[3:0]] <= bit_w;
  always @(negedge cs_n) cs_falls++;
  task conclude; begin
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  end endtask
  // one link bit, 160 ns period
  task lbit(input b, input e); begin
    ldat <= b; len <= e;
    repeat (4) @(posedge clk); lclk <= 1'b1;
    repeat (4) @(posedge clk); lclk <= 1'b0;
  end endtask
  // one load; extra bits before enable and after the image must be ignored
  task load(input [1:0] m, input [15:0] v); integer i; begin
    got <= 16'h0; mode_sel <= m; config_reset_n <= 1'b0;
    repeat (8) @(posedge clk);
    config_reset_n <= 1'b1;
    if (m == `FCL_MODE_PASSIVE || m == `FCL_MODE_JTAG) begin
      lbit(1'b1, 1'b0);
      for (i = 15; i >= 0; i--) lbit(v[i], 1'b1);
      lbit(1'b1, 1'b1);
      len <= 1'b0;
    end
    i = 0;
    while (done !== 1'b1 && i < 5000) begin @(posedge clk); i++; end
    repeat (4) @(posedge clk);
    `CHK(got, v)
    `CHK(user, 1'b1)
  end endtask
  task t_active; begin
    load(`FCL_MODE_ACTIVE, 16'hc3a5);
    `CHK(wake, `FCL_CMD_WAKE)
    `CHK(hdr, {`FCL_CMD_FAST_READ, `FCL_START_ADDR})
  end endtask
  task t_passive; load(`FCL_MODE_PASSIVE, 16'h5a0f); endtask
  task t_jtag; load(`FCL_MODE_JTAG, 16'h0ff0); endtask
  task t_mask; integer f; begin
    f = cs_falls;
    load(`FCL_MODE_MASK, MASK_IMG);
    `CHK(cs_falls, f)
  end endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_active; t_passive; t_jtag; t_mask;
    conclude;
  end
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    conclude;
  end
endmodule // testbench
bind fcl_loader fcl_chk #(.IMAGE_BITS(IMAGE_BITS), .WAKE_CYC(WAKE_CYC)) chk (.clk(clk),
  .rst_b(rst_b), .mode_sel(mode_sel), .config_reset_n(config_reset_n),
  .flash_sck(flash_sck), .flash_cs_n(flash_cs_n), .flash_mosi(flash_mosi),
  .cfg_we(cfg_we), .cfg_addr(cfg_addr), .config_done(config_done), .user_mode(user_mode));
